/* hdl/mssc_pkg.sv */
// Package of the math-store, service-request and sub-sampling command block.
// Assumes a single 250 MHz clock domain and a command decoder upstream.
package mssc_pkg;

  localparam int MSSC_VAL_W = 32;
  localparam int MSSC_IDX_W = 5;
  localparam int MSSC_NUM_REGS = 16;

  // Register indices
  localparam logic [4:0] IDX_FILTER_TIME_CONSTANT = 5'h01;
  localparam logic [4:0] IDX_LOWER = 5'h02;
  localparam logic [4:0] IDX_PASS_MAX = 5'h03;
  localparam logic [4:0] IDX_READING_AVERAGE = 5'h04;
  localparam logic [4:0] IDX_PASS_MIN = 5'h05;
  localparam logic [4:0] IDX_STAT_SAMPLE_COUNT = 5'h06;
  localparam logic [4:0] IDX_OFFSET = 5'h07;
  localparam logic [4:0] IDX_RATIO_TARGET_VALUE = 5'h08;
  localparam logic [4:0] IDX_DB_REF = 5'h09;
  localparam logic [4:0] IDX_LOAD_IMPEDANCE_VALUE = 5'h0a;
  localparam logic [4:0] IDX_SCALE_DIVISOR = 5'h0b;
  localparam logic [4:0] IDX_HOLE = 5'h0c;
  localparam logic [4:0] IDX_UPPER = 5'h0d;
  localparam logic [4:0] IDX_SPARE_VALUE = 5'h0e;
  localparam logic [4:0] IDX_PASSES_BEFORE_FAIL = 5'h0f;

  // Power-on contents
  localparam logic [31:0] RST_FILTER_TIME_CONSTANT = 32'h0000_0014;
  localparam logic [31:0] RST_LOAD_IMPEDANCE_VALUE = 32'h0000_0032;
  localparam logic [31:0] RST_ONE = 32'h0000_0001;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  // Status bit set by the service-request command, and its mask weight
  localparam int STB_SRQ_CMD_BIT = 2;
  localparam logic [7:0] STB_SRQ_CMD_WEIGHT = 8'h04;
  localparam logic [7:0] RST_SERVICE_MASK = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [31:0] RST_SAMPLE_COUNT = 32'h0000_0001;

  // Range codes, peak thresholds in microvolts
  typedef enum logic [2:0] {
    MSSC_RNG_10MV = 3'h0,
    MSSC_RNG_100MV = 3'h1,
    MSSC_RNG_1V = 3'h2,
    MSSC_RNG_10V = 3'h3,
    MSSC_RNG_100V = 3'h4,
    MSSC_RNG_1000V = 3'h5,
    MSSC_RNG_BAD = 3'h7
  } mssc_range_type;
  localparam logic [31:0] PEAK_10MV_UV = 32'h0000_2ee0;    // .012 V
  localparam logic [31:0] PEAK_100MV_UV = 32'h0001_d4c0;   // .120 V
  localparam logic [31:0] PEAK_1V_UV = 32'h0012_4f80;      // 1.2 V
  localparam logic [31:0] PEAK_10V_UV = 32'h00b7_1b00;     // 12 V
  localparam logic [31:0] PEAK_100V_UV = 32'h0727_0e00;    // 120 V
  localparam logic [31:0] PEAK_1000V_UV = 32'h3b9a_ca00;   // 1E3 V

  // Level trigger ceiling in percent of range; short-integer ceiling
  localparam logic [15:0] LEVEL_MAX_PCT = 16'h01f4;  // 500
  localparam logic [15:0] SHORT_INTEGER_FORMAT_MAX_PCT = 16'h0078;   // 120

  // Least effective interval
  localparam int MIN_EFF_INTERVAL_NS = 10;
  localparam int CLK_PERIOD_NS = 4;
  localparam logic [31:0] MIN_EFF_INTERVAL_PS = 32'h0000_2710;

  localparam logic [1:0] FMT_SHORT_INT = 2'h0;
  localparam logic [1:0] RST_OUT_FMT = 2'h0;

  typedef enum logic [3:0] {
    MSSC_FUNC_NONE = 4'h0,
    MSSC_FUNC_AC_SS = 4'h1,
    MSSC_FUNC_DC_SS = 4'h2,
    MSSC_FUNC_OTHER = 4'h3
  } mssc_func_type;

  typedef struct packed {
    logic has_index;
    logic [4:0] index;
    logic has_value;
    logic [31:0] value;
  } mssc_store_type;

  typedef struct packed {
    logic [31:0] value;
    logic [4:0] index;
  } mssc_mrec_type;

  typedef struct packed {
    logic ac_only;
    logic has_peak;
    logic [31:0] peak_uv;
    logic has_resolution;
    logic [31:0] resolution;
  } mssc_ss_type;

  typedef struct packed {
    logic fifo_mode;
    logic empty;
    logic [1:0] mem_format;
  } mssc_mem_type;

  typedef struct packed {
    logic [15:0] bursts_n;
    logic [15:0] bursts_n1;
    logic [15:0] n;
  } mssc_parm_type;

endpackage

/* hdl/mssc_fifo.sv */
// FIFO of sample words with valid/ready on both sides.
// Assumes one clock; depth a power of two.
module mssc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  // Pointers wrap by bit width, so only powers of two are served
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("mssc_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic push, pop;
  always_comb begin
    o_in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    o_out_valid = wr_ptr != rd_ptr;
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    next_wr_ptr = wr_ptr + (AW+1)'(push);
    next_rd_ptr = rd_ptr + (AW+1)'(pop);
    o_out_data = mem[rd_ptr[AW-1:0]];
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end
endmodule

/* hdl/mssc_core.sv */
// Command block: math-register store, service request, sub-sampling setup.
// Assumes a decoder on i_ref_clk that pulses one command at a time.
module mssc_core import mssc_pkg::*; #(
  parameter int SAMPLE_W = 16,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_store_math_cmd,
  input wire mssc_store_type i_store,
  input wire logic [31:0] i_last_reading,
  input wire logic i_running_statistics_on,
  input wire logic i_pass_fail_check_on,
  input wire logic i_srq_cmd,
  input wire logic i_service_enable_cmd,
  input wire logic [7:0] i_service_mask,
  input wire logic [7:0] i_status_events,
  input wire logic i_clear_status,
  input wire logic i_subsample_cmd,
  input wire mssc_ss_type i_ss,
  input wire logic i_other_func_cmd,
  input wire logic i_set_out_fmt,
  input wire logic [1:0] i_out_fmt,
  input wire logic [15:0] i_level_pct,
  input wire logic i_sweep_cmd,
  input wire logic [31:0] i_sweep_interval_ps,
  input wire logic [31:0] i_sweep_count,
  input wire logic i_reading_count_cmd,
  input wire logic i_mem_enabled,
  input wire mssc_mem_type i_mem,
  input wire logic i_trigger_arm_event,
  input wire logic i_trigger_event,
  input wire logic i_sample_event,
  input wire logic i_sync_event,
  input wire logic i_sample_valid,
  input wire logic [SAMPLE_W-1:0] i_sample,
  input wire mssc_parm_type i_burst_parms,
  input wire logic i_out_ready,
  output logic o_out_valid,
  output logic [SAMPLE_W-1:0] o_out_sample,
  output logic o_sample_ready,
  output logic o_srq,
  output logic [7:0] o_status,
  output logic o_cmd_error,
  output logic o_config_clash_error,
  output logic o_subsampling,
  output logic o_ac_only,
  output mssc_range_type o_range,
  output logic o_autozero_en,
  output logic o_autorange_en,
  output logic [1:0] o_out_fmt,
  output logic o_reorder_to_mem,
  output logic o_level_ok,
  output logic o_short_integer_format_overrange,
  output logic [31:0] o_eff_interval_ps,
  output logic [31:0] o_sample_count,
  output mssc_parm_type o_subsample_params_query,
  output logic o_take_burst,
  output logic [31:0] o_math_reg [MSSC_NUM_REGS]
);
  if (SAMPLE_W < 1 || FIFO_DEPTH < 2) begin : g_bad_parms
    $error("mssc_core parameters out of range");
  end

  // ----------------------------------------------------------------
  // Math registers
  // ----------------------------------------------------------------
  logic [31:0] math_reg [MSSC_NUM_REGS];
  logic [31:0] next_math_reg [MSSC_NUM_REGS];
  logic [4:0] st_idx;
  logic [31:0] st_val;
  logic st_ok;

  function automatic logic [31:0] reset_value(input int i);
    logic [31:0] v;
    v = RST_ZERO;
    if (5'(i) == IDX_FILTER_TIME_CONSTANT) v = RST_FILTER_TIME_CONSTANT;
    if (5'(i) == IDX_LOAD_IMPEDANCE_VALUE) v = RST_LOAD_IMPEDANCE_VALUE;
    if (5'(i) == IDX_RATIO_TARGET_VALUE || 5'(i) == IDX_DB_REF ||
        5'(i) == IDX_SCALE_DIVISOR) v = RST_ONE;
    return v;
  endfunction

  always_comb begin
    st_idx = i_store.has_index ? i_store.index
                               : IDX_FILTER_TIME_CONSTANT;
    // All ones is stored as given, never read as a default
    st_val = i_store.has_value ? i_store.value : i_last_reading;
    st_ok = st_idx != '0 && st_idx != IDX_HOLE &&
            st_idx <= IDX_PASSES_BEFORE_FAIL;
    for (int i = 0; i < MSSC_NUM_REGS; i++) begin
      next_math_reg[i] = math_reg[i];
    end
    if (i_store_math_cmd && st_ok) begin
      next_math_reg[st_idx[3:0]] = st_val;
    end
    // Live statistics take precedence over any stored value
    if (i_running_statistics_on) begin
      if (i_last_reading > math_reg[IDX_UPPER[3:0]])
        next_math_reg[IDX_UPPER[3:0]] = i_last_reading;
      if (i_last_reading < math_reg[IDX_LOWER[3:0]])
        next_math_reg[IDX_LOWER[3:0]] = i_last_reading;
    end
    if (i_pass_fail_check_on) begin
      next_math_reg[IDX_PASSES_BEFORE_FAIL[3:0]] = i_last_reading;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < MSSC_NUM_REGS; i++) begin
        math_reg[i] <= reset_value(i);
      end
      o_cmd_error <= 1'b0;
    end else begin
      for (int i = 0; i < MSSC_NUM_REGS; i++) begin
        math_reg[i] <= next_math_reg[i];
      end
      o_cmd_error <= i_store_math_cmd && !st_ok;
    end
  end
  assign o_math_reg = math_reg;

  // ----------------------------------------------------------------
  // Status and service request
  // ----------------------------------------------------------------
  logic [7:0] status, next_status, mask, next_mask;
  always_comb begin
    next_mask = i_service_enable_cmd ? i_service_mask : mask;
    // Set wins over a clear in the same cycle
    next_status = (i_clear_status ? 8'h00 : status) | i_status_events;
    if (i_srq_cmd) next_status[STB_SRQ_CMD_BIT] = 1'b1;
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      status <= RST_STATUS;
      mask <= RST_SERVICE_MASK;
    end else begin
      status <= next_status;
      mask <= next_mask;
    end
  end
  assign o_status = status;
  assign o_srq = |(status & mask);

  // ----------------------------------------------------------------
  // Sub-sampling configuration
  // ----------------------------------------------------------------
  logic ss, next_ss, ac, next_ac, forced, next_forced;
  logic [1:0] fmt, next_fmt, saved_fmt, next_saved_fmt;
  mssc_range_type rng, next_rng, sel_rng;
  logic [31:0] eff, next_eff, cnt, next_cnt;

  always_comb begin
    if (!i_ss.has_peak) sel_rng = MSSC_RNG_10V;
    else if (i_ss.peak_uv <= PEAK_10MV_UV) sel_rng = MSSC_RNG_10MV;
    else if (i_ss.peak_uv <= PEAK_100MV_UV) sel_rng = MSSC_RNG_100MV;
    else if (i_ss.peak_uv <= PEAK_1V_UV) sel_rng = MSSC_RNG_1V;
    else if (i_ss.peak_uv <= PEAK_10V_UV) sel_rng = MSSC_RNG_10V;
    else if (i_ss.peak_uv <= PEAK_100V_UV) sel_rng = MSSC_RNG_100V;
    else if (i_ss.peak_uv <= PEAK_1000V_UV) sel_rng = MSSC_RNG_1000V;
    else sel_rng = MSSC_RNG_BAD;
    next_ss = ss;
    next_ac = ac;
    next_rng = rng;
    next_fmt = fmt;
    next_saved_fmt = saved_fmt;
    next_forced = forced;
    next_eff = eff;
    next_cnt = cnt;
    if (i_set_out_fmt) next_fmt = i_out_fmt;
    // Resolution field is never read
    if (i_subsample_cmd && sel_rng != MSSC_RNG_BAD) begin
      next_ss = 1'b1;
      next_ac = i_ss.ac_only;
      next_rng = sel_rng;
      if (!i_mem_enabled) begin
        if (!forced) next_saved_fmt = fmt;
        next_fmt = FMT_SHORT_INT;
        next_forced = 1'b1;
      end // memory enabled keeps fmt
    end else if (i_other_func_cmd) begin
      next_ss = 1'b0;
      if (forced) next_fmt = saved_fmt;
      next_forced = 1'b0;
    end
    if (i_sweep_cmd && i_sweep_interval_ps >= MIN_EFF_INTERVAL_PS) begin
      next_eff = i_sweep_interval_ps;
      next_cnt = i_sweep_count;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ss <= 1'b0;
      ac <= 1'b0;
      rng <= MSSC_RNG_10V;
      fmt <= RST_OUT_FMT;
      saved_fmt <= RST_OUT_FMT;
      forced <= 1'b0;
      eff <= MIN_EFF_INTERVAL_PS;
      cnt <= RST_SAMPLE_COUNT;
    end else begin
      ss <= next_ss;
      ac <= next_ac;
      rng <= next_rng;
      fmt <= next_fmt;
      saved_fmt <= next_saved_fmt;
      forced <= next_forced;
      eff <= next_eff;
      cnt <= next_cnt;
    end
  end

  assign o_subsampling = ss;
  assign o_ac_only = ac;
  assign o_range = rng;
  assign o_out_fmt = fmt;
  assign o_autozero_en = !ss;
  assign o_autorange_en = !ss;
  assign o_eff_interval_ps = eff;
  assign o_sample_count = cnt;
  assign o_level_ok = i_level_pct <= LEVEL_MAX_PCT;
  assign o_short_integer_format_overrange = i_level_pct > SHORT_INTEGER_FORMAT_MAX_PCT;
  assign o_reorder_to_mem = ss && i_mem_enabled;
  assign o_subsample_params_query = i_burst_parms;

  // ----------------------------------------------------------------
  // Arm check and event gating
  // ----------------------------------------------------------------
  logic armed, next_armed, clash, next_clash, mem_ok;
  logic nrdg_err, next_nrdg_err;
  always_comb begin
    mem_ok = i_mem.fifo_mode && i_mem.empty &&
             i_mem.mem_format == FMT_SHORT_INT;
    next_armed = armed;
    next_clash = 1'b0;
    next_nrdg_err = ss && i_reading_count_cmd;
    if (!ss) next_armed = 1'b0;
    // Trigger and sample events have no path into this logic
    else if (i_trigger_arm_event) begin
      if (i_mem_enabled && !mem_ok) begin
        next_armed = 1'b0;
        next_clash = 1'b1;
      end else begin
        next_armed = 1'b1;
      end
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      armed <= 1'b0;
      clash <= 1'b0;
      nrdg_err <= 1'b0;
    end else begin
      armed <= next_armed;
      clash <= next_clash;
      nrdg_err <= next_nrdg_err;
    end
  end
  assign o_config_clash_error = clash | nrdg_err;
  assign o_take_burst = armed && i_sync_event;

  // ----------------------------------------------------------------
  // Sample buffer
  // ----------------------------------------------------------------
  logic fifo_in_ready;
  mssc_fifo #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_in_valid(i_sample_valid && armed),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_sample),
    .o_out_valid(o_out_valid),
    .i_out_ready(i_out_ready),
    .o_out_data(o_out_sample)
  );
  assign o_sample_ready = fifo_in_ready && armed;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_srq_sets_bit: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_srq_cmd |=> status[STB_SRQ_CMD_BIT])
    else $error("srq command did not set bit 2");
  chk_srq_line: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_srq_cmd && mask[STB_SRQ_CMD_BIT] && !i_service_enable_cmd |=> o_srq)
    else $error("srq line not asserted");
  chk_bad_index: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_store_math_cmd && i_store.has_index && i_store.index == IDX_HOLE
    |=> o_cmd_error)
    else $error("index 12 not rejected");
  chk_store_default: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_store_math_cmd && !i_store.has_index && i_store.has_value
    |=> math_reg[1] == $past(i_store.value))
    else $error("default store target wrong");
  // Live math functions may legally overwrite a store, so they are excluded
  chk_store_lands: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_store_math_cmd && st_ok && !i_running_statistics_on && !i_pass_fail_check_on
    |=> math_reg[$past(st_idx[3:0])] == $past(st_val))
    else $error("stored value not in register");
  chk_force_short_integer_format: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_subsample_cmd && !i_mem_enabled && i_ss.has_peak == 1'b0
    |=> fmt == FMT_SHORT_INT && o_range == MSSC_RNG_10V)
    else $error("format not forced");
  chk_fmt_restore: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_other_func_cmd && !i_subsample_cmd && !i_set_out_fmt && forced
    |=> fmt == $past(saved_fmt))
    else $error("output format not restored");
  chk_mem_keeps_fmt: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    i_subsample_cmd && i_mem_enabled && !i_set_out_fmt
    |=> fmt == $past(fmt))
    else $error("output format changed with memory on");
  chk_auto_off: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    ss |-> !o_autozero_en && !o_autorange_en)
    else $error("auto functions active in sub-sampling");
  chk_arm_clash: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    ss && i_trigger_arm_event && i_mem_enabled && !i_mem.empty
    |=> o_config_clash_error && !armed)
    else $error("arm check missed");
  chk_events_ignored: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    ss && !i_trigger_arm_event |=> armed == $past(armed))
    else $error("arm state moved without an arm event");
  chk_count_refused: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    ss && i_reading_count_cmd && !i_sweep_cmd
    |=> o_config_clash_error && cnt == $past(cnt))
    else $error("reading count accepted in sub-sampling");
  chk_min_interval: assert property (
    @(posedge i_ref_clk) disable iff (i_rst)
    eff >= MIN_EFF_INTERVAL_PS)
    else $error("interval below minimum");
  cov_srq: cover property (@(posedge i_ref_clk) i_srq_cmd ##1 o_srq);
  cov_arm: cover property (@(posedge i_ref_clk) ss && i_trigger_arm_event
    ##1 armed);
  cov_clash: cover property (@(posedge i_ref_clk) clash);
  cov_restore: cover property (@(posedge i_ref_clk)
    forced && i_other_func_cmd);
  cov_burst: cover property (@(posedge i_ref_clk) o_take_burst);
endmodule

/* verification/mssc_ctl_model.sv */
// Model of the remote controller that reads the sample stream.
// Assumes one clock; ready changes only at the falling edge.
module mssc_ctl_model (
  input wire logic i_ref_clk,
  input wire logic i_stall,
  input wire logic i_valid,
  input wire logic [15:0] i_data,
  output logic o_ready,
  output int o_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] got [64];

  initial begin
    o_ready = 1'b0;
    o_count = 0;
  end

  // ---------------------------------------------------------------------
  // Capture
  // ---------------------------------------------------------------------
  // Words kept in arrival order; waveform rebuilding is left to the bench
  always @(posedge i_ref_clk) begin
    if (i_valid && o_ready && o_count < 64) begin
      got[o_count] <= i_data;
      o_count <= o_count + 1;
    end
  end

  always @(negedge i_ref_clk) begin
    o_ready <= !i_stall;
  end
endmodule

/* verification/math_store_srq_subsample_config_tb.sv */
// Self-checking bench of the command block with a sample sink.
// Assumes the core with a 16-word sample buffer and a 4 ns clock.
module math_store_srq_subsample_config_tb import mssc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst, store_cmd, running_statistics_on, pass_fail_check_on, srq_cmd, se_cmd;
  logic clr_st, ss_cmd, oth_cmd, set_fmt, swp_cmd, rc_cmd, mem_en, arm_ev;
  logic trg_ev, smp_ev, sync_ev, s_valid, stall, o_valid, p_ready;
  logic s_ready, srq, cmd_err, clash, subs, ac, azero, arange, reord;
  logic lvl_ok, short_integer_format_ov, take;
  logic [1:0] fmt, ofmt;
  logic [7:0] mask, ev, status;
  logic [15:0] lvl, smp, o_smp;
  logic [31:0] last_rd, swp_int, swp_cnt, eff, cnt;
  logic [31:0] mreg [MSSC_NUM_REGS];
  mssc_store_type st;
  mssc_ss_type ss;
  mssc_mem_type mem;
  mssc_parm_type bp, pq;
  mssc_range_type rng;
  int err_count, cmp_count, pcount;

  mssc_core #(.SAMPLE_W(16), .FIFO_DEPTH(16)) u_mssc_core (
    .i_ref_clk(ref_clk), .i_rst(rst), .i_store_math_cmd(store_cmd),
    .i_store(st), .i_last_reading(last_rd), .i_running_statistics_on(running_statistics_on),
    .i_pass_fail_check_on(pass_fail_check_on), .i_srq_cmd(srq_cmd),
    .i_service_enable_cmd(se_cmd), .i_service_mask(mask),
    .i_status_events(ev), .i_clear_status(clr_st),
    .i_subsample_cmd(ss_cmd), .i_ss(ss), .i_other_func_cmd(oth_cmd),
    .i_set_out_fmt(set_fmt), .i_out_fmt(fmt), .i_level_pct(lvl),
    .i_sweep_cmd(swp_cmd), .i_sweep_interval_ps(swp_int),
    .i_sweep_count(swp_cnt), .i_reading_count_cmd(rc_cmd),
    .i_mem_enabled(mem_en), .i_mem(mem), .i_trigger_arm_event(arm_ev),
    .i_trigger_event(trg_ev), .i_sample_event(smp_ev),
    .i_sync_event(sync_ev), .i_sample_valid(s_valid), .i_sample(smp),
    .i_burst_parms(bp), .i_out_ready(p_ready), .o_out_valid(o_valid),
    .o_out_sample(o_smp), .o_sample_ready(s_ready), .o_srq(srq),
    .o_status(status), .o_cmd_error(cmd_err),
    .o_config_clash_error(clash), .o_subsampling(subs), .o_ac_only(ac),
    .o_range(rng), .o_autozero_en(azero), .o_autorange_en(arange),
    .o_out_fmt(ofmt), .o_reorder_to_mem(reord), .o_level_ok(lvl_ok),
    .o_short_integer_format_overrange(short_integer_format_ov), .o_eff_interval_ps(eff),
    .o_sample_count(cnt), .o_subsample_params_query(pq),
    .o_take_burst(take), .o_math_reg(mreg));

  mssc_ctl_model u_mssc_ctl_model (
    .i_ref_clk(ref_clk), .i_stall(stall), .i_valid(o_valid),
    .i_data(o_smp), .o_ready(p_ready), .o_count(pcount));

  always #2 ref_clk = ~ref_clk;

  // ---------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    if (err_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Commands are held across exactly one rising edge; one idle edge first
  // so that back-to-back pulses never lower and raise in one time step
  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask

  task automatic store(input logic hi, input logic [4:0] idx,
                       input logic hv, input logic [31:0] v);
    st = '{hi, idx, hv, v};
    pulse(store_cmd);
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_reset;
    for (int i = 1; i < 16; i++) begin
      check(mreg[i], i == 1 ? 32'h14 : i == 10 ? 32'h32 :
            (i == 8 || i == 9 || i == 11) ? 32'h1 : 32'h0);
    end
  endtask

  task automatic t_store;
    logic [4:0] bad [4] = '{5'h00, 5'h0c, 5'h10, 5'h1f};
    for (int i = 1; i < 16; i++) begin
      if (i != 12) begin
        store(1'b1, 5'(i), 1'b1, 32'h100 + i);
        check(mreg[i], 32'h100 + i);
      end
    end
    foreach (bad[j]) begin
      store(1'b1, bad[j], 1'b1, 32'hdead);
      check(cmd_err, 1'b1);
      check({mreg[12], mreg[1]}, {32'h0, 32'h101});
    end
    store(1'b0, 5'h0d, 1'b1, 32'h55);
    check({mreg[1], mreg[13]}, {32'h55, 32'h10d});
    last_rd = 32'h777;
    store(1'b1, 5'h0a, 1'b0, 32'h0);
    check(mreg[10], 32'h777);
    store(1'b1, 5'h0e, 1'b1, 32'hffff_ffff);
    check(mreg[14], 32'hffff_ffff);
    store(1'b1, 5'h0d, 1'b1, 32'h5);
    store(1'b1, 5'h0f, 1'b1, 32'h9);
    check({mreg[13], mreg[15]}, {32'h5, 32'h9});
    last_rd = 32'h7fff_0000;
    {running_statistics_on, pass_fail_check_on} = 2'b11;
    @(negedge ref_clk);
    {running_statistics_on, pass_fail_check_on} = 2'b00;
    check({mreg[13], mreg[15]}, {2{32'h7fff_0000}});
    check(mreg[2], 32'h102);
  endtask

  task automatic t_srq;
    pulse(se_cmd);
    pulse(srq_cmd);
    check(status[2], 1'b1);
    check(srq, 1'b0);
    pulse(clr_st);
    mask = 8'h04;
    pulse(se_cmd);
    check(srq, 1'b0);
    pulse(srq_cmd);
    check(srq, 1'b1);
    pulse(clr_st);
    mask = 8'h01;
    pulse(se_cmd);
    ev = 8'h01;
    @(negedge ref_clk);
    ev = 8'h00;
    check({status[0], srq}, 2'b11);
    pulse(clr_st);
  endtask

  task automatic t_ss;
    logic [31:0] pk [6] = '{PEAK_10MV_UV, PEAK_100MV_UV, PEAK_1V_UV,
                           PEAK_10V_UV, PEAK_100V_UV, PEAK_1000V_UV};
    fmt = 2'h2;
    pulse(set_fmt);
    ss = '{1'b1, 1'b0, 32'h0, 1'b1, 32'h1234};
    pulse(ss_cmd);
    check(rng, MSSC_RNG_10V);
    check(ofmt, FMT_SHORT_INT);
    check({azero, arange, subs, ac}, 4'h3);
    pulse(oth_cmd);
    check(ofmt, 2'h2);
    mem_en = 1'b1;
    ss.ac_only = 1'b0;
    pulse(ss_cmd);
    check({ofmt, ac}, 3'h4);
    for (int i = 0; i < 6; i++) begin
      ss = '{1'b0, 1'b1, pk[i], 1'b1, 32'(i)};
      pulse(ss_cmd);
      check(rng, i);
      ss.peak_uv = pk[i] + 1;
      pulse(ss_cmd);
      check(rng, i < 5 ? i + 1 : 5);
    end
    lvl = 16'h01f4;
    @(negedge ref_clk);
    check({lvl_ok, short_integer_format_ov}, 2'b11);
    lvl = 16'h01f5;
    @(negedge ref_clk);
    check(lvl_ok, 1'b0);
    lvl = 16'h0078;
    @(negedge ref_clk);
    check({lvl_ok, short_integer_format_ov}, 2'b10);
    bp = '{16'h2, 16'h2, 16'h6};
    @(negedge ref_clk);
    check(pq, {16'h2, 16'h2, 16'h6});
  endtask

  task automatic t_arm;
    mssc_mem_type bm [3] = '{'{1'b1, 1'b0, 2'h0}, '{1'b0, 1'b1, 2'h0},
                             '{1'b1, 1'b1, 2'h1}};
    swp_int = 32'h270f;
    swp_cnt = 32'hc8;
    pulse(swp_cmd);
    check(eff, 32'h2710);
    swp_int = 32'h4c4b40;
    pulse(swp_cmd);
    check({eff, cnt}, {32'h4c4b40, 32'hc8});
    pulse(rc_cmd);
    check({clash, cnt}, {1'b1, 32'hc8});
    foreach (bm[j]) begin
      mem = bm[j];
      pulse(arm_ev);
      check(clash, 1'b1);
      sync_ev = 1'b1;
      @(negedge ref_clk);
      check(take, 1'b0);
      sync_ev = 1'b0;
    end
    mem = '{1'b1, 1'b1, FMT_SHORT_INT};
    pulse(arm_ev);
    check(clash, 1'b0);
    trg_ev = 1'b1;
    smp_ev = 1'b1;
    @(negedge ref_clk);
    {trg_ev, smp_ev} = 2'b00;
    check({take, subs, reord}, 3'h3);
    sync_ev = 1'b1;
    @(negedge ref_clk);
    check(take, 1'b1);
    sync_ev = 1'b0;
  endtask

  // Buffer fills against a stalled sink, then drains with stop-go reads
  task automatic t_fifo;
    int k;
    k = 0;
    s_valid = 1'b1;
    smp = 16'h0;
    for (int n = 0; n < 40 && s_ready === 1'b1; n++) begin
      @(negedge ref_clk);
      k++;
      smp = 16'(k);
    end
    s_valid = 1'b0;
    check(k, 16);
    for (int n = 0; n < 200 && pcount < 16; n++) begin
      stall = n[0];
      @(negedge ref_clk);
    end
    stall = 1'b1;
    check(pcount, 16);
    for (int i = 0; i < 16; i++) check(u_mssc_ctl_model.got[i], i);
    check(o_valid, 1'b0);
  endtask

  initial begin
    {store_cmd, running_statistics_on, pass_fail_check_on, srq_cmd, se_cmd, clr_st, ss_cmd,
     oth_cmd, set_fmt, swp_cmd, rc_cmd, mem_en, arm_ev, trg_ev, smp_ev,
     sync_ev, s_valid, fmt, mask, ev, lvl, smp, last_rd, swp_int,
     swp_cnt} = '0;
    {st, ss, mem, bp} = '0;
    ref_clk = 1'b0;
    rst = 1'b1;
    stall = 1'b1;
    err_count = 0;
    cmp_count = 0;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    t_reset;
    t_store;
    t_srq;
    t_ss;
    t_arm;
    t_fifo;
    end_sim;
  end
endmodule
